// ---- ict_bus.sv ----
`timescale 1ns/1ps
module ict_bus (
  // clock, reset and enable
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic ce,
  // sequencer side
  ict_bus_if.bus    io
);

  typedef struct packed {
    logic       busy;
    logic       write;
    logic [1:0] phase;
  } ict_bus_st_t;

  ict_bus_st_t cur_ff;
  ict_bus_st_t nxt_st;

  // the start cycle is the first clock of the cycle, so back-to-back cycles leave no gap
  always_comb begin
    nxt_st     = cur_ff;
    io.ready   = !cur_ff.busy;
    io.waiting = cur_ff.busy && (cur_ff.phase == ict_pkg::BUS_PH_LAST) && io.mem_wait;
    io.done    = ce && cur_ff.busy && (cur_ff.phase == ict_pkg::BUS_PH_LAST) && !io.mem_wait;
    io.rd_act  = (io.start && !io.write) || (cur_ff.busy && !cur_ff.write);
    io.wr_act  = (io.start && io.write) || (cur_ff.busy && cur_ff.write);
    if (io.start && !cur_ff.busy) begin
      nxt_st.busy  = 1'b1;
      nxt_st.write = io.write;
      nxt_st.phase = ict_pkg::BUS_PH_FIRST;
    end else if (cur_ff.busy) begin
      if (cur_ff.phase != ict_pkg::BUS_PH_LAST) begin
        nxt_st.phase = cur_ff.phase + ict_pkg::BUS_PH_FIRST;
      end else if (!io.mem_wait) begin
        nxt_st.busy = 1'b0;
      end
      // memory holding the last phase stretches the cycle one clock at a time
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '0;
    end else if (ce) begin
      cur_ff <= nxt_st;
    end
  end

  sequence s_clean_cycle;
    io.start && io.ready ##1 !io.mem_wait [*3];
  endsequence

  property p_bus_four;
    @(posedge clk) disable iff (!rst_b || !ce)
    s_clean_cycle |-> io.done;
  endproperty
  a_bus_four: assert property (p_bus_four) else $error("bus cycle did not end on its fourth clock");

  property p_bus_wait;
    @(posedge clk) disable iff (!rst_b || !ce)
    io.waiting |=> cur_ff.busy && (cur_ff.phase == ict_pkg::BUS_PH_LAST);
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("wait state did not hold the bus cycle");

endmodule

// ---- ict_bus_if.sv ----
`timescale 1ns/1ps
// one bus cycle request between the sequencer and the bus timer
interface ict_bus_if;
  logic start;
  logic write;
  logic mem_wait;
  logic ready;
  logic done;
  logic rd_act;
  logic wr_act;
  logic waiting;

  modport seq (output start, write, mem_wait, input ready, done, rd_act, wr_act, waiting);
  modport bus (input start, write, mem_wait, output ready, done, rd_act, wr_act, waiting);
endinterface

// ---- ict_core.sv ----
`timescale 1ns/1ps
module ict_core (
  // clock, reset, enable
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire logic           ce,
  // timing request
  input  wire logic           req_valid,
  output logic                req_ready,
  input  ict_pkg::ict_kind_t  req_kind,
  input  ict_pkg::ict_size_t  req_size,
  input  ict_pkg::ict_mode_t  req_src,
  input  ict_pkg::ict_mode_t  req_dst,
  input  wire logic           req_idx_long,
  // memory bus activity
  input  wire logic           mem_wait,
  output logic                bus_read,
  output logic                bus_write,
  output logic                bus_idle,
  // result
  output logic                done,
  output logic                busy,
  output logic [7:0]          total_clk,
  output logic [3:0]          read_cnt,
  output logic [3:0]          write_cnt,
  output logic [15:0]         elapsed_clk,
  output logic [15:0]         wait_clk
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_INT   = 2'h2,
    ST_WRITE = 2'h3
  } ict_state_t;

  typedef struct packed {
    ict_state_t         state;
    ict_pkg::ict_kind_t kind;
    ict_pkg::ict_cost_t cost;
    logic [3:0]         rd_left;
    logic [3:0]         wr_left;
    logic [7:0]         idle_left;
    logic [3:0]         rd_seen;
    logic [3:0]         wr_seen;
    logic [15:0]        elapsed;
    logic [15:0]        waits;
    logic [15:0]        elapsed_out;
    logic [15:0]        waits_out;
  } ict_core_st_t;

  ict_core_st_t       cur_ff;
  ict_core_st_t       nxt_st;
  ict_pkg::ict_req_t  req;
  ict_pkg::ict_cost_t lookup;
  logic               accept;
  logic               last;
  logic [4:0]         rw_sum;

  ict_bus_if bus_io ();

  assign req = '{req_kind, req_size, req_src, req_dst, req_idx_long};

  ict_cost u_cost (
    .req  (req),
    .cost (lookup)
  );

  ict_bus u_bus (
    .clk   (clk),
    .rst_b (rst_b),
    .ce    (ce),
    .io    (bus_io.bus)
  );

  // pick the next phase: reads, then internal clocks, then writes
  function automatic ict_state_t pick(input logic [3:0] rd, input logic [7:0] idl, input logic [3:0] wr);
    ict_state_t s;
    s = ST_IDLE;
    if (rd != 4'h0) begin
      s = ST_READ;
    end else if (idl != 8'h00) begin
      s = ST_INT;
    end else if (wr != 4'h0) begin
      s = ST_WRITE;
    end
    return s;
  endfunction

  // handshake outputs are combinational; results come from the state register
  assign req_ready       = (cur_ff.state == ST_IDLE);
  assign accept          = ce && req_valid && req_ready;
  assign bus_io.mem_wait = mem_wait;
  assign bus_read        = bus_io.rd_act;
  assign bus_write       = bus_io.wr_act;
  assign bus_idle        = (cur_ff.state == ST_INT);
  assign done            = last;
  assign busy            = (cur_ff.state != ST_IDLE);
  assign total_clk       = cur_ff.cost.clk;
  assign read_cnt        = cur_ff.cost.rd;
  assign write_cnt       = cur_ff.cost.wr;
  assign elapsed_clk     = cur_ff.elapsed_out;
  assign wait_clk        = cur_ff.waits_out;

  // sequencer: spends the figure as four-clock bus cycles plus idle clocks
  always_comb begin
    nxt_st       = cur_ff;
    last         = 1'b0;
    bus_io.start = 1'b0;
    bus_io.write = 1'b0;
    rw_sum       = 5'(lookup.rd) + 5'(lookup.wr);
    if (cur_ff.state != ST_IDLE) begin
      // every clock of the run is counted, stretched ones included
      nxt_st.elapsed = cur_ff.elapsed + 16'h0001;
      if (bus_io.waiting) begin
        nxt_st.waits = cur_ff.waits + 16'h0001;
      end
    end
    case (cur_ff.state)
      ST_IDLE: begin
        if (accept) begin
          // one figure: total clocks with its read and write counts
          nxt_st.kind      = req_kind;
          nxt_st.cost      = lookup;
          nxt_st.rd_left   = lookup.rd;
          nxt_st.wr_left   = lookup.wr;
          nxt_st.idle_left = lookup.clk - 8'(rw_sum) * ict_pkg::BUS_CLKS;
          nxt_st.rd_seen   = 4'h0;
          nxt_st.wr_seen   = 4'h0;
          nxt_st.elapsed   = 16'h0000;
          nxt_st.waits     = 16'h0000;
          nxt_st.state     = pick(nxt_st.rd_left, nxt_st.idle_left, nxt_st.wr_left);
          // a register direct operand finishes at once
          last             = (nxt_st.state == ST_IDLE);
        end
      end
      ST_READ: begin
        if (ce && bus_io.ready && cur_ff.rd_left != 4'h0) begin
          bus_io.start   = 1'b1;
          nxt_st.rd_left = cur_ff.rd_left - 4'h1;
          nxt_st.rd_seen = cur_ff.rd_seen + 4'h1;
        end
        if (bus_io.done && cur_ff.rd_left == 4'h0) begin
          nxt_st.state = pick(4'h0, cur_ff.idle_left, cur_ff.wr_left);
          last         = (nxt_st.state == ST_IDLE);
        end
      end
      ST_INT: begin
        // bus stays quiet while the core finishes its internal work
        nxt_st.idle_left = cur_ff.idle_left - 8'h01;
        if (cur_ff.idle_left == 8'h01) begin
          nxt_st.state = pick(4'h0, 8'h00, cur_ff.wr_left);
          last         = ce && (nxt_st.state == ST_IDLE);
        end
      end
      ST_WRITE: begin
        bus_io.write = 1'b1;
        if (ce && bus_io.ready && cur_ff.wr_left != 4'h0) begin
          bus_io.start   = 1'b1;
          nxt_st.wr_left = cur_ff.wr_left - 4'h1;
          nxt_st.wr_seen = cur_ff.wr_seen + 4'h1;
        end
        if (bus_io.done && cur_ff.wr_left == 4'h0) begin
          nxt_st.state = ST_IDLE;
          last         = 1'b1;
        end
      end
      default: begin
        nxt_st.state = ST_IDLE;
      end
    endcase
    if (last) begin
      // totals include opcode, extension, operand fetch and store clocks
      nxt_st.elapsed_out = nxt_st.elapsed;
      nxt_st.waits_out   = nxt_st.waits;
    end
  end

  // all state frozen while the enable is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff <= '0;
    end else if (ce) begin
      cur_ff <= nxt_st;
    end
  end

  sequence s_accept_ind_short;
    accept && req_kind == ict_pkg::KIND_EA && req_src == ict_pkg::MODE_IND && req_size != ict_pkg::SZ_LONG;
  endsequence

  sequence s_accept_long_mem;
    accept && req_kind == ict_pkg::KIND_MOVE && req_size == ict_pkg::SZ_LONG && req_dst == ict_pkg::MODE_IND;
  endsequence

  property p_total;
    @(posedge clk) disable iff (!rst_b || !ce)
    done && busy |=> elapsed_clk == 16'(total_clk) + wait_clk;
  endproperty
  a_total: assert property (p_total) else $error("run length differs from figure plus waits");

  property p_counts;
    @(posedge clk) disable iff (!rst_b || !ce)
    done && busy |-> cur_ff.rd_seen == cur_ff.cost.rd && cur_ff.wr_seen == cur_ff.cost.wr;
  endproperty
  a_counts: assert property (p_counts) else $error("bus cycle counts differ from figure");

  property p_ea_nowrite;
    @(posedge clk) disable iff (!rst_b || !ce)
    busy && cur_ff.kind == ict_pkg::KIND_EA |-> !bus_write;
  endproperty
  a_ea_nowrite: assert property (p_ea_nowrite) else $error("address calculation wrote to memory");

  property p_ea_ind;
    @(posedge clk) disable iff (!rst_b || !ce)
    s_accept_ind_short |=> total_clk == ict_pkg::BUS_CLKS && read_cnt == 4'h1;
  endproperty
  a_ea_ind: assert property (p_ea_ind) else $error("indirect operand figure wrong");

  property p_move_long;
    @(posedge clk) disable iff (!rst_b || !ce)
    s_accept_long_mem |=> write_cnt == 4'h2 ##1 bus_read;
  endproperty
  a_move_long: assert property (p_move_long) else $error("long move to memory lacks two writes");

  property p_reg_direct;
    @(posedge clk) disable iff (!rst_b || !ce)
    accept && req_kind == ict_pkg::KIND_EA && (req_src == ict_pkg::MODE_DREG || req_src == ict_pkg::MODE_AREG)
      |-> done ##1 !busy;
  endproperty
  a_reg_direct: assert property (p_reg_direct) else $error("register direct operand took time");

  property p_idle;
    @(posedge clk) disable iff (!rst_b || !ce)
    cur_ff.state == ST_INT |-> bus_idle && !bus_read && !bus_write;
  endproperty
  a_idle: assert property (p_idle) else $error("bus active during internal clocks");

endmodule

// ---- ict_cost.sv ----
`timescale 1ns/1ps
module ict_cost (
  // request
  input  ict_pkg::ict_req_t  req,
  // figure
  output ict_pkg::ict_cost_t cost
);

  logic      is_long;
  logic      modes_ok;
  ict_pkg::ict_cost_t src_c;
  ict_pkg::ict_cost_t dst_c;

  // idx_long is deliberately unused: index width never changes the figure
  always_comb begin
    is_long  = (req.size == ict_pkg::SZ_LONG);
    modes_ok = (int'(req.src) < ict_pkg::MODE_COUNT) && (int'(req.dst) < ict_pkg::MODE_COUNT);
    src_c    = ict_pkg::COST_ZERO;
    dst_c    = ict_pkg::COST_ZERO;
    cost     = ict_pkg::COST_ZERO;
    if (modes_ok) begin
      // tables hold no writes for address calculation
      src_c = is_long ? ict_pkg::EA_LONG[req.src] : ict_pkg::EA_SHORT[req.src];
      dst_c = is_long ? ict_pkg::DST_LONG[req.dst] : ict_pkg::DST_SHORT[req.dst];
      if (req.kind == ict_pkg::KIND_EA) begin
        cost = src_c;
      end else begin
        // opcode fetch plus source fetch plus destination store
        cost.clk = ict_pkg::MOVE_BASE.clk + src_c.clk + dst_c.clk;
        cost.rd  = ict_pkg::MOVE_BASE.rd + src_c.rd + dst_c.rd;
        cost.wr  = ict_pkg::MOVE_BASE.wr + src_c.wr + dst_c.wr;
      end
    end
  end

endmodule

// ---- ict_mem_model.sv ----
`timescale 1ns/1ps
// memory on the far side of the core's bus: stretches every bus cycle by wait_n clocks
module ict_mem_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // bus activity from the core
  input  wire logic       bus_read,
  input  wire logic       bus_write,
  // wait clocks per bus cycle, set by the bench
  input  wire logic [3:0] wait_n,
  // stall request back to the core
  output logic            mem_wait
);
  typedef struct packed {
    logic [1:0] ph;
    logic [3:0] left;
  } ict_mem_st_t;

  ict_mem_st_t state_ff;
  ict_mem_st_t nxt_state;
  logic        active;

  // stall only in the last phase of a cycle, one clock per remaining wait
  assign active   = bus_read | bus_write;
  assign mem_wait = active && (state_ff.ph == 2'h3) && (state_ff.left != 4'h0);

  // phase tracker; wait budget is reloaded at the first clock of every cycle
  always_comb begin
    nxt_state = state_ff;
    if (active) begin
      if (state_ff.ph == 2'h0) begin
        nxt_state.left = wait_n;
        nxt_state.ph   = 2'h1;
      end else if (state_ff.ph == 2'h3 && state_ff.left != 4'h0) begin
        nxt_state.left = state_ff.left - 4'h1;
      end else begin
        nxt_state.ph = state_ff.ph + 2'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end
endmodule

// ---- ict_pkg.sv ----
// Operation
// - zero-wait bus cycle lasts four clocks
// - wait clocks add to instruction total
// - figures give clocks, reads and writes
// - total covers fetches and operand stores
// - address calculation never writes
// - indirect, postincrement, immediate: 4(1/0), 8(2/0)
// - predecrement: 6(1/0), long 10(2/0)
// - displacement, absolute short: 8(2/0), 12(3/0)
// - indexed modes: 10(2/0), long 14(3/0)
// - absolute long: 12(3/0), long 16(4/0)
// - index size never changes timing
// - byte/word moves follow source-destination matrix
// - long moves write memory destination twice
package ict_pkg;

  // operand addressing modes
  typedef enum logic [3:0] {
    MODE_DREG    = 4'h0,
    MODE_AREG    = 4'h1,
    MODE_IND     = 4'h2,
    MODE_POSTINC = 4'h3,
    MODE_PREDEC  = 4'h4,
    MODE_DISP    = 4'h5,
    MODE_INDEX   = 4'h6,
    MODE_ABSW    = 4'h7,
    MODE_ABSL    = 4'h8,
    MODE_PCDISP  = 4'h9,
    MODE_PCINDEX = 4'hA,
    MODE_IMM     = 4'hB
  } ict_mode_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } ict_size_t;

  typedef enum logic {
    KIND_EA   = 1'h0,
    KIND_MOVE = 1'h1
  } ict_kind_t;

  // one timing figure: clocks, read cycles, write cycles
  typedef struct packed {
    logic [7:0] clk;
    logic [3:0] rd;
    logic [3:0] wr;
  } ict_cost_t;

  typedef struct packed {
    ict_kind_t kind;
    ict_size_t size;
    ict_mode_t src;
    ict_mode_t dst;
    logic      idx_long;
  } ict_req_t;

  localparam int        CLK_PERIOD_NS  = 5;
  localparam logic [7:0] BUS_CLKS      = 8'h04;
  localparam logic [1:0] BUS_PH_FIRST  = 2'h1;
  localparam logic [1:0] BUS_PH_LAST   = 2'h3;
  localparam int        MODE_COUNT     = 12;

  localparam ict_cost_t COST_ZERO = '{8'h00, 4'h0, 4'h0};
  localparam ict_cost_t MOVE_BASE = '{8'h04, 4'h1, 4'h0};

  // source operand cost, byte/word, indexed by mode
  localparam ict_cost_t EA_SHORT [MODE_COUNT] = '{
    '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h04, 4'h1, 4'h0}, '{8'h04, 4'h1, 4'h0},
    '{8'h06, 4'h1, 4'h0}, '{8'h08, 4'h2, 4'h0}, '{8'h0A, 4'h2, 4'h0}, '{8'h08, 4'h2, 4'h0},
    '{8'h0C, 4'h3, 4'h0}, '{8'h08, 4'h2, 4'h0}, '{8'h0A, 4'h2, 4'h0}, '{8'h04, 4'h1, 4'h0}};

  localparam ict_cost_t EA_LONG [MODE_COUNT] = '{
    '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h08, 4'h2, 4'h0}, '{8'h08, 4'h2, 4'h0},
    '{8'h0A, 4'h2, 4'h0}, '{8'h0C, 4'h3, 4'h0}, '{8'h0E, 4'h3, 4'h0}, '{8'h0C, 4'h3, 4'h0},
    '{8'h10, 4'h4, 4'h0}, '{8'h0C, 4'h3, 4'h0}, '{8'h0E, 4'h3, 4'h0}, '{8'h08, 4'h2, 4'h0}};

  // destination store cost of a move; pc-relative and immediate cannot be destinations
  localparam ict_cost_t DST_SHORT [MODE_COUNT] = '{
    '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h04, 4'h0, 4'h1}, '{8'h04, 4'h0, 4'h1},
    '{8'h04, 4'h0, 4'h1}, '{8'h08, 4'h1, 4'h1}, '{8'h0A, 4'h1, 4'h1}, '{8'h08, 4'h1, 4'h1},
    '{8'h0C, 4'h2, 4'h1}, '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}};

  localparam ict_cost_t DST_LONG [MODE_COUNT] = '{
    '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h08, 4'h0, 4'h2}, '{8'h08, 4'h0, 4'h2},
    '{8'h08, 4'h0, 4'h2}, '{8'h0C, 4'h1, 4'h2}, '{8'h0E, 4'h1, 4'h2}, '{8'h0C, 4'h1, 4'h2},
    '{8'h10, 4'h2, 4'h2}, '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}, '{8'h00, 4'h0, 4'h0}};

endpackage

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic                clk, rst_b, ce, req_valid, req_idx_long, mem_wait;
  logic                req_ready, bus_read, bus_write, bus_idle, done, busy;
  ict_pkg::ict_kind_t  req_kind;
  ict_pkg::ict_size_t  req_size;
  ict_pkg::ict_mode_t  req_src, req_dst;
  logic [7:0]          total_clk;
  logic [3:0]          read_cnt, write_cnt, wait_n;
  logic [15:0]         elapsed_clk, wait_clk;
  int                  bad_count, num_checks;

  ict_core i_ict_core (.clk(clk), .rst_b(rst_b), .ce(ce), .req_valid(req_valid), .req_ready(req_ready),
    .req_kind(req_kind), .req_size(req_size), .req_src(req_src), .req_dst(req_dst),
    .req_idx_long(req_idx_long), .mem_wait(mem_wait), .bus_read(bus_read), .bus_write(bus_write),
    .bus_idle(bus_idle), .done(done), .busy(busy), .total_clk(total_clk), .read_cnt(read_cnt),
    .write_cnt(write_cnt), .elapsed_clk(elapsed_clk), .wait_clk(wait_clk));

  ict_mem_model i_ict_mem_model (.clk(clk), .rst_b(rst_b), .bus_read(bus_read), .bus_write(bus_write),
    .wait_n(wait_n), .mem_wait(mem_wait));

  // 200 MHz clock
  always #(ict_pkg::CLK_PERIOD_NS / 2.0) clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // drive one request, count bus clocks until done, then judge figures and counters
  task automatic run(input logic k, input logic [1:0] s, input logic [3:0] a, input logic [3:0] b,
                     input logic [7:0] n, input logic [3:0] r, input logic [3:0] w, input logic [3:0] wt);
    int  cyc, rc, wc, ic, ws;
    logic fin;
    ws = wt * (r + w);
    wait_n = wt;
    @(negedge clk);
    req_valid = 1'b1;
    req_kind  = ict_pkg::ict_kind_t'(k);
    req_size  = ict_pkg::ict_size_t'(s);
    req_src   = ict_pkg::ict_mode_t'(a);
    req_dst   = ict_pkg::ict_mode_t'(b);
    #1 fin = (done === 1'b1);
    cyc = 0; rc = 0; wc = 0; ic = 0;
    @(negedge clk);
    req_valid = 1'b0;
    while (!fin && cyc < 300) begin
      rc += int'(bus_read === 1'b1);
      wc += int'(bus_write === 1'b1);
      ic += int'(bus_idle === 1'b1);
      cyc++;
      fin = (done === 1'b1);
      if (!fin) @(negedge clk);
    end
    @(negedge clk);
    chk(total_clk, n);
    chk(read_cnt, r);
    chk(write_cnt, w);
    chk(16'(cyc), 16'(n) + 16'(ws));
    chk(elapsed_clk, 16'(n) + 16'(ws));
    chk(wait_clk, 16'(ws));
    chk(16'(rc), 16'((4 + wt) * r));
    chk(16'(wc), 16'((4 + wt) * w));
    chk(16'(ic), 16'(n) - 16'(4 * (r + w)));
  endtask

  // address calculation figure worked out per mode: {clocks, reads}
  function automatic logic [11:0] ea_exp(input logic [3:0] m, input logic lg);
    logic [11:0] e;
    case (m)
      4'h0, 4'h1:        e = 12'h000;
      4'h2, 4'h3, 4'hB:  e = 12'h041;
      4'h4:              e = 12'h061;
      4'h5, 4'h7, 4'h9:  e = 12'h082;
      4'h6, 4'hA:        e = 12'h0A2;
      default:           e = 12'h0C3;
    endcase
    if (lg && e != 12'h000) e = e + 12'h041;
    return e;
  endfunction

  // every mode, short and long; index size flipped so both settings meet indexed modes
  task automatic t_ea_modes();
    logic [11:0] e;
    for (int i = 0; i < 12; i++) begin
      for (int lg = 0; lg < 2; lg++) begin
        e = ea_exp(4'(i), lg[0]);
        req_idx_long = i[0] ^ lg[0];
        run(1'b0, lg[0] ? 2'h2 : {1'b0, i[0]}, 4'(i), 4'h0, e[11:4], e[3:0], 4'h0, 4'h0);
      end
    end
    req_idx_long = 1'b0;
  endtask

  // move matrix corners, byte/word and long
  task automatic t_moves();
    run(1'b1, 2'h1, 4'h0, 4'h0, 8'h04, 4'h1, 4'h0, 4'h0);
    run(1'b1, 2'h0, 4'h0, 4'h2, 8'h08, 4'h1, 4'h1, 4'h0);
    run(1'b1, 2'h1, 4'h8, 4'h8, 8'h1C, 4'h6, 4'h1, 4'h0);
    run(1'b1, 2'h1, 4'h4, 4'h6, 8'h14, 4'h3, 4'h1, 4'h0);
    run(1'b1, 2'h2, 4'h0, 4'h2, 8'h0C, 4'h1, 4'h2, 4'h0);
    run(1'b1, 2'h2, 4'h4, 4'h6, 8'h1C, 4'h4, 4'h2, 4'h0);
    // unknown mode costs nothing, size code 3 counts as short, pc-relative destination stores nothing
    run(1'b0, 2'h1, 4'hC, 4'h0, 8'h00, 4'h0, 4'h0, 4'h0);
    run(1'b0, 2'h3, 4'h2, 4'h0, 8'h04, 4'h1, 4'h0, 4'h0);
    run(1'b1, 2'h1, 4'h0, 4'h9, 8'h04, 4'h1, 4'h0, 4'h0);
  endtask

  // slow memory stretches reads and writes alike
  task automatic t_waits();
    run(1'b0, 2'h1, 4'h2, 4'h0, 8'h04, 4'h1, 4'h0, 4'h2);
    run(1'b1, 2'h2, 4'h8, 4'h8, 8'h24, 4'h7, 4'h2, 4'h1);
    wait_n = 4'h0;
  endtask

  // a request held high while busy is ignored, then taken the cycle after done
  task automatic t_refuse();
    int cyc;
    @(negedge clk);
    req_valid = 1'b1;
    req_kind  = ict_pkg::KIND_EA;
    req_size  = ict_pkg::SZ_LONG;
    req_src   = ict_pkg::MODE_ABSL;
    @(negedge clk);
    req_kind  = ict_pkg::KIND_MOVE;
    req_size  = ict_pkg::SZ_WORD;
    req_src   = ict_pkg::MODE_DREG;
    req_dst   = ict_pkg::MODE_DREG;
    chk({15'h0, req_ready}, 16'h0000);
    chk({15'h0, busy}, 16'h0001);
    cyc = 0;
    while (done !== 1'b1 && cyc < 100) begin
      @(negedge clk);
      cyc++;
    end
    chk(16'(cyc), 16'h000F);
    @(negedge clk);
    chk(total_clk, 8'h10);
    chk(read_cnt, 4'h4);
    @(negedge clk);
    req_valid = 1'b0;
    chk(total_clk, 8'h04);
    cyc = 0;
    while (busy !== 1'b0 && cyc < 100) begin
      @(negedge clk);
      cyc++;
    end
    chk({15'h0, busy}, 16'h0000);
  endtask

  // enable low during the idle clocks freezes the run; frozen clocks are not counted
  task automatic t_hold();
    int cyc;
    @(negedge clk);
    req_valid = 1'b1;
    req_kind  = ict_pkg::KIND_EA;
    req_size  = ict_pkg::SZ_WORD;
    req_src   = ict_pkg::MODE_PREDEC;
    @(negedge clk);
    req_valid = 1'b0;
    cyc = 0;
    while (bus_idle !== 1'b1 && cyc < 20) begin
      @(negedge clk);
      cyc++;
    end
    ce = 1'b0;
    repeat (3) @(negedge clk);
    chk({14'h0, bus_idle, done}, 16'h0002);
    ce = 1'b1;
    cyc = 0;
    while (done !== 1'b1 && cyc < 20) begin
      @(negedge clk);
      cyc++;
    end
    chk(16'(cyc), 16'h0001);
    @(negedge clk);
    chk(elapsed_clk, 16'h0006);
  endtask

  // watchdog: the whole run needs a few hundred cycles
  initial begin
    #100000;
    bad_count++;
    stop_test();
  end

  // reset, then scenarios
  initial begin
    clk = 1'b0; rst_b = 1'b0; ce = 1'b1; req_valid = 1'b0; req_idx_long = 1'b0; wait_n = 4'h0;
    req_kind = ict_pkg::KIND_EA; req_size = ict_pkg::SZ_BYTE;
    req_src = ict_pkg::MODE_DREG; req_dst = ict_pkg::MODE_DREG;
    bad_count = 0; num_checks = 0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    chk({15'h0, req_ready}, 16'h0001);
    t_ea_modes();
    t_moves();
    t_waits();
    t_refuse();
    t_hold();
    stop_test();
  end
endmodule
